// file: pcpl_panel.sv
// Model of the front panel, remote inputs and fault circuits.
// Assumes the block's pclk; command lines idle high via their pull-ups.
`timescale 1ns/100ps
module pcpl_panel
    import pcpl_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 40
) (
    input wire logic pclk,
    output pcpl_cmd_s local_cmd_n,
    output pcpl_cmd_s remote_cmd_n,
    output logic vswr_fault,
    output logic severe_fault,
    output logic interlock_fault
);
    int unsigned held_cyc;
    initial begin
        local_cmd_n = '1;
        remote_cmd_n = '1;
        {vswr_fault, severe_fault, interlock_fault} = 3'h0;
        held_cyc = 0;
    end
    always @(posedge pclk) begin
        if (&local_cmd_n && &remote_cmd_n) held_cyc <= 0;
        else held_cyc <= held_cyc + 1;
    end
    task automatic hold(input logic rem, input logic [5:0] act);
        @(posedge pclk);
        if (rem) remote_cmd_n <= ~act;
        else local_cmd_n <= ~act;
    endtask
    // A short press would be lost in the debouncer, so release waits it out
    task automatic release_all();
        while (held_cyc < HOLD_CYCLES) @(posedge pclk);
        local_cmd_n <= '1;
        remote_cmd_n <= '1;
    endtask
    task automatic fault(input logic [2:0] f);
        {vswr_fault, severe_fault, interlock_fault} <= f;
    endtask
endmodule

// file: pcpl_pkg.sv
// Constants, field layout and types for the power command priority latch.
// Assumes a 20 MHz pclk; all timing counts derive from CLK_HZ.
package pcpl_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_HZ = 200;
    localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
    localparam int unsigned INHIBIT_MS = 250;
    localparam int unsigned DELAY_MS = 20;
    localparam int unsigned PULSE_MS = 10;
    localparam int unsigned INHIBIT_CYC = CLK_HZ / 1000 * INHIBIT_MS;
    localparam int unsigned DELAY_CYC = CLK_HZ / 1000 * DELAY_MS;
    localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
    localparam int TMR_W = 23;

    // Input must disagree with the output on this many ticks in a row
    localparam logic [2:0] DEB_TICKS = 3'h4;

    // Command channel indices, lowest priority first
    localparam int CMD_N = 6;
    localparam int C_LOW = 0;
    localparam int C_MED = 1;
    localparam int C_HIGH = 2;
    localparam int C_RAISE = 3;
    localparam int C_LOWER = 4;
    localparam int C_OFF = 5;
    localparam logic [2:0] CODE_NONE = 3'h0;
    localparam logic [2:0] CODE_BASE = 3'h2;

    // Same bit order as the channel indices
    typedef struct packed {
        logic off;
        logic lower;
        logic raise;
        logic high;
        logic med;
        logic low;
    } pcpl_cmd_s;

    // Stored power level
    typedef struct packed {
        logic off;
        logic high;
        logic med;
        logic low;
    } pcpl_lvl_s;

    typedef enum logic [2:0] {
        LC_IDLE = 3'h1,
        LC_DELAY = 3'h2,
        LC_PULSE = 3'h4
    } pcpl_lc_e;

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DEBOUNCE = 12'h008;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // Status field positions
    localparam int ST_LATCH = 0;
    localparam int ST_GATED = 4;
    localparam int ST_TURN_ON = 7;
    localparam int ST_INHIBIT_N = 8;
    localparam int ST_DEC_INH = 9;
    localparam int ST_LC_BUSY = 10;
    localparam int ST_CODE = 11;

endpackage

// file: pcpl_top.sv
// Power command priority latch: debounce, priority pick, decode inhibit,
// level-change pulse, backed-up level latch, contactor gating, APB registers.
// Assumes command pins are asynchronous and active low; backup_rst_n comes
// from the backup supply monitor and is the only clear of the level latch.
`timescale 1ns/100ps

// Overview of operation
// [R01] Remote commands ignored while selector is local
// [R02] VSWR fault lowers; severe or interlock fault offs
// [R03] Six debounce channels on shared 200 Hz tick
// [R04] Debounced output changes after 3-4 stable ticks
// [R05] Issuer holds command low at least 20 ms
// [R06] Highest priority wins: off, lower, raise, high, med, low
// [R07] Encoder always on, switches code at once
// [R08] Decoder: one low output, all high when idle
// [R09] Latched off rising starts 0.25 s decode inhibit
// [R10] Supply fault clears decode inhibit immediately
// [R11] Raise and lower pass through, never latched
// [R12] Off, high, med, low ORed into level change
// [R13] 20 ms delay then 10 ms low change pulse
// [R14] Off with level still present: pulse at once
// [R15] Supply fault suppresses level change pulse
// [R16] Change pulse ORed with other strobes
// [R17] Level latch cleared only by backup reset
// [R18] Stored off triggers inhibit and contactor inhibit
// [R19] Level outputs ANDed with contactor inhibit line
// [R20] Any gated level high raises turn-on request
// [R21] Contactor inhibit on severe, secondary fault or off
// [R22] Tick and timers from pclk, lengths as parameters
module pcpl_top #(
    parameter int unsigned TICK_CYCLES = pcpl_pkg::TICK_CYC,
    parameter int unsigned INHIBIT_CYCLES = pcpl_pkg::INHIBIT_CYC,
    parameter int unsigned DELAY_CYCLES = pcpl_pkg::DELAY_CYC,
    parameter int unsigned PULSE_CYCLES = pcpl_pkg::PULSE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic backup_rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pcpl_pkg::pcpl_cmd_s local_cmd_n,
    input wire pcpl_pkg::pcpl_cmd_s remote_cmd_n,
    input wire logic local_sel,
    input wire logic vswr_fault,
    input wire logic severe_fault,
    input wire logic interlock_fault,
    input wire logic secondary_fault,
    input wire logic supply_fault_n,
    input wire logic other_strobe,
    output logic debounce_tick,
    output pcpl_pkg::pcpl_cmd_s dec_n,
    output logic raise_cmd,
    output logic lower_cmd,
    output logic level_change_n,
    output logic data_strobe,
    output pcpl_pkg::pcpl_lvl_s power_level_latch,
    output logic [2:0] gated_level,
    output logic contactor_inhibit_n,
    output logic turn_on_request
);
    import pcpl_pkg::*;

    localparam int SYN_W = 2 * CMD_N + 6;
    // Idle pin levels, so leaving reset shows no false command or supply fault
    localparam logic [SYN_W-1:0] PIN_IDLE = {{(2 * CMD_N){1'b1}}, 6'h01};
    localparam logic [TMR_W-1:0] TICK_LAST = TMR_W'(TICK_CYCLES - 1);
    localparam logic [TMR_W-1:0] INH_LAST = TMR_W'(INHIBIT_CYCLES - 1);
    localparam logic [TMR_W-1:0] DLY_LAST = TMR_W'(DELAY_CYCLES - 1);
    localparam logic [TMR_W-1:0] PLS_LAST = TMR_W'(PULSE_CYCLES - 1);

    function automatic logic [2:0] prio_code(input logic [CMD_N-1:0] act);
        logic [2:0] c;
        c = CODE_NONE;
        for (int i = 0; i < CMD_N; i++) begin
            if (act[i]) begin
                c = CODE_BASE + 3'(i);
            end
        end
        return c;
    endfunction

    // Three-stage synchroniser; a change counts once stages two and three agree
    logic [SYN_W-1:0] pin_raw;
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    logic [SYN_W-1:0] syn3_reg;
    logic [SYN_W-1:0] pin_f_reg;

    assign pin_raw = {local_cmd_n, remote_cmd_n, local_sel, vswr_fault, severe_fault,
                      interlock_fault, secondary_fault, supply_fault_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syn1_reg <= PIN_IDLE;
            syn2_reg <= PIN_IDLE;
            syn3_reg <= PIN_IDLE;
            pin_f_reg <= PIN_IDLE;
        end else begin
            syn1_reg <= pin_raw;
            syn2_reg <= syn1_reg;
            syn3_reg <= syn2_reg;
            if (syn2_reg == syn3_reg) begin
                pin_f_reg <= syn3_reg;
            end
        end
    end

    logic [CMD_N-1:0] local_f_n;
    logic [CMD_N-1:0] remote_f_n;
    logic local_sel_f;
    logic vswr_f;
    logic severe_f;
    logic interlock_f;
    logic secondary_f;
    logic supply_ok_f;

    assign local_f_n = pin_f_reg[SYN_W-1 -: CMD_N];
    assign remote_f_n = pin_f_reg[CMD_N+5 -: CMD_N];
    assign local_sel_f = pin_f_reg[5];
    assign vswr_f = pin_f_reg[4];
    assign severe_f = pin_f_reg[3];
    assign interlock_f = pin_f_reg[2];
    assign secondary_f = pin_f_reg[1];
    assign supply_ok_f = pin_f_reg[0];

    // Software commands act like an extra parallel source on each line
    logic [CMD_N-1:0] ctrl_reg;
    logic [CMD_N-1:0] cmd_raw_n;

    always_comb begin
        cmd_raw_n = local_f_n & ~ctrl_reg;
        if (!local_sel_f) begin
            cmd_raw_n = cmd_raw_n & remote_f_n; // see [R01]
        end
        if (vswr_f) begin
            cmd_raw_n[C_LOWER] = 1'b0; // see [R02]
        end
        if (severe_f || interlock_f) begin
            cmd_raw_n[C_OFF] = 1'b0; // see [R02]
        end
    end

    // Slow tick shared by the debouncer and exported
    logic [TMR_W-1:0] tick_cnt_reg;
    logic tick_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= '0; // see [R22]
            tick_reg <= 1'b1; // see [R03]
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    assign debounce_tick = tick_reg;

    // Any disagreement that does not last resets the channel count
    logic [CMD_N-1:0] deb_n_reg;
    logic [2:0] deb_cnt_reg [CMD_N];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deb_n_reg <= '1;
            for (int i = 0; i < CMD_N; i++) begin
                deb_cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CMD_N; i++) begin
                if (cmd_raw_n[i] == deb_n_reg[i]) begin
                    deb_cnt_reg[i] <= '0;
                end else if (tick_reg) begin
                    if (deb_cnt_reg[i] == DEB_TICKS - 3'h1) begin
                        deb_n_reg[i] <= cmd_raw_n[i]; // see [R04] [R05]
                        deb_cnt_reg[i] <= '0;
                    end else begin
                        deb_cnt_reg[i] <= deb_cnt_reg[i] + 3'h1;
                    end
                end
            end
        end
    end

    // Encoder is never gated; only the decoder sees the inhibit
    logic [CMD_N-1:0] deb_act;
    logic [2:0] code;
    logic dinh_reg;
    logic [CMD_N-1:0] dec_next;
    logic [CMD_N-1:0] dec_n_reg;

    assign deb_act = ~deb_n_reg;
    assign code = prio_code(deb_act); // see [R06] [R07]

    always_comb begin
        for (int i = 0; i < CMD_N; i++) begin
            dec_next[i] = !(!dinh_reg && code == CODE_BASE + 3'(i)); // see [R08]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_n_reg <= '1;
        end else begin
            dec_n_reg <= dec_next;
        end
    end

    assign dec_n = dec_n_reg;
    assign raise_cmd = !dec_n_reg[C_RAISE]; // see [R11]
    assign lower_cmd = !dec_n_reg[C_LOWER]; // see [R11]

    // Level-change sequencer
    pcpl_lvl_s dec_lvl;
    logic lvl_any;
    logic lvl_new;
    logic off_now;
    pcpl_lvl_s dec_lvl_reg;
    pcpl_lvl_s pend_reg;
    pcpl_lc_e lc_state_reg;
    logic [TMR_W-1:0] lc_cnt_reg;
    logic lcn_reg;

    assign dec_lvl = '{off: !dec_n_reg[C_OFF], high: !dec_n_reg[C_HIGH],
                       med: !dec_n_reg[C_MED], low: !dec_n_reg[C_LOW]};
    assign lvl_any = |dec_lvl; // see [R12]
    assign lvl_new = lvl_any && dec_lvl != dec_lvl_reg;
    // A fault-made off during turn-on must not wait for the delay
    assign off_now = lvl_new && dec_lvl.off &&
                     |{deb_act[C_HIGH], deb_act[C_MED], deb_act[C_LOW]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_lvl_reg <= '0;
            pend_reg <= '0;
            lc_state_reg <= LC_IDLE;
            lc_cnt_reg <= '0;
            lcn_reg <= 1'b1;
        end else begin
            dec_lvl_reg <= dec_lvl;
            if (!supply_ok_f) begin
                lc_state_reg <= LC_IDLE; // see [R15]
                lc_cnt_reg <= '0;
                lcn_reg <= 1'b1;
            end else if (off_now) begin
                pend_reg <= dec_lvl;
                lc_state_reg <= LC_PULSE; // see [R14]
                lc_cnt_reg <= '0;
                lcn_reg <= 1'b0;
            end else if (lvl_new) begin
                pend_reg <= dec_lvl;
                lc_state_reg <= LC_DELAY; // see [R13]
                lc_cnt_reg <= '0;
                lcn_reg <= 1'b1;
            end else begin
                case (lc_state_reg)
                    LC_IDLE: begin
                        lcn_reg <= 1'b1;
                    end
                    LC_DELAY: begin
                        if (lc_cnt_reg == DLY_LAST) begin
                            lc_state_reg <= LC_PULSE; // see [R13]
                            lc_cnt_reg <= '0;
                            lcn_reg <= 1'b0;
                        end else begin
                            lc_cnt_reg <= lc_cnt_reg + 1'b1;
                        end
                    end
                    LC_PULSE: begin
                        if (lc_cnt_reg == PLS_LAST) begin
                            lc_state_reg <= LC_IDLE;
                            lc_cnt_reg <= '0;
                            lcn_reg <= 1'b1;
                        end else begin
                            lc_cnt_reg <= lc_cnt_reg + 1'b1;
                        end
                    end
                    default: begin
                        lc_state_reg <= LC_IDLE;
                        lcn_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign level_change_n = lcn_reg;

    logic strobe_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= !lcn_reg || other_strobe; // see [R16]
        end
    end

    assign data_strobe = strobe_reg;

    // Lives on the backup supply: system reset must not touch it
    pcpl_lvl_s latch_reg;
    logic lcn_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcn_d_reg <= 1'b1;
        end else begin
            lcn_d_reg <= lcn_reg;
        end
    end

    always_ff @(posedge pclk or negedge backup_rst_n) begin
        if (!backup_rst_n) begin
            latch_reg <= '0; // see [R17]
        end else if (!lcn_reg && lcn_d_reg) begin
            latch_reg <= pend_reg; // see [R13] [R17]
        end
    end

    assign power_level_latch = latch_reg;

    // Decode inhibit one-shot, started by the stored off
    logic off_d_reg;
    logic [TMR_W-1:0] dinh_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_d_reg <= 1'b0;
            dinh_reg <= 1'b0;
            dinh_cnt_reg <= '0;
        end else begin
            off_d_reg <= latch_reg.off;
            if (!supply_ok_f) begin
                dinh_reg <= 1'b0; // see [R10]
                dinh_cnt_reg <= '0;
            end else if (latch_reg.off && !off_d_reg) begin
                dinh_reg <= 1'b1; // see [R09] [R18]
                dinh_cnt_reg <= '0;
            end else if (dinh_reg) begin
                if (dinh_cnt_reg == INH_LAST) begin
                    dinh_reg <= 1'b0;
                end
                dinh_cnt_reg <= dinh_cnt_reg + 1'b1;
            end
        end
    end

    // Contactor gating and turn-on request
    logic inh_n_next;
    logic [2:0] gated_next;
    logic inh_n_reg;
    logic [2:0] gated_reg;
    logic ton_reg;

    assign inh_n_next = !(severe_f || secondary_f || latch_reg.off); // see [R21] [R18]
    assign gated_next = {latch_reg.high, latch_reg.med, latch_reg.low} &
                        {3{inh_n_next}}; // see [R19]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_n_reg <= 1'b0;
            gated_reg <= '0;
            ton_reg <= 1'b0;
        end else begin
            inh_n_reg <= inh_n_next;
            gated_reg <= gated_next;
            ton_reg <= |gated_next; // see [R20]
        end
    end

    assign contactor_inhibit_n = inh_n_reg;
    assign gated_level = gated_reg;
    assign turn_on_request = ton_reg;

    // APB slave: read data captured in setup, answer in the first access cycle
    logic mapped;
    logic [31:0] rdata_next;
    logic [31:0] prdata_reg;

    assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_DEBOUNCE;

    always_comb begin
        rdata_next = '0;
        case (paddr)
            ADDR_CTRL: begin
                rdata_next[CMD_N-1:0] = ctrl_reg;
            end
            ADDR_STATUS: begin
                rdata_next[ST_LATCH +: 4] = latch_reg;
                rdata_next[ST_GATED +: 3] = gated_reg;
                rdata_next[ST_TURN_ON] = ton_reg;
                rdata_next[ST_INHIBIT_N] = inh_n_reg;
                rdata_next[ST_DEC_INH] = dinh_reg;
                rdata_next[ST_LC_BUSY] = lc_state_reg != LC_IDLE;
                rdata_next[ST_CODE +: 3] = code;
            end
            ADDR_DEBOUNCE: begin
                rdata_next[CMD_N-1:0] = deb_act;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            ctrl_reg <= CTRL_RST;
        end else begin
            if (psel && !penable) begin
                prdata_reg <= rdata_next;
            end
            if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
                ctrl_reg <= pwdata[CMD_N-1:0];
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_remote_local;
        (local_sel_f && ctrl_reg == '0 && local_f_n == '1 && !vswr_f && !severe_f &&
         !interlock_f) |-> cmd_raw_n == '1;
    endproperty
    a_remote_local: assert property (p_remote_local) else $error("remote acted in local"); // see [R01]

    property p_fault_cmd;
        (vswr_f |-> !cmd_raw_n[C_LOWER]) and (interlock_f |-> !cmd_raw_n[C_OFF]);
    endproperty
    a_fault_cmd: assert property (p_fault_cmd) else $error("fault command missing"); // see [R02]

    property p_deb_on_tick;
        (deb_n_reg != $past(deb_n_reg)) |-> $past(tick_reg);
    endproperty
    a_deb_on_tick: assert property (p_deb_on_tick) else $error("debounce moved off tick"); // see [R04]

    property p_off_wins;
        (deb_act[C_OFF] && !dinh_reg) |=> !dec_n_reg[C_OFF] && $countones(~dec_n_reg) == 1;
    endproperty
    a_off_wins: assert property (p_off_wins) else $error("off not selected"); // see [R06]

    property p_dec_onehot;
        ($countones(~dec_n_reg) <= 1) and (dinh_reg |=> dec_n_reg == '1);
    endproperty
    a_dec_onehot: assert property (p_dec_onehot) else $error("decoder not one-hot"); // see [R08]

    property p_inh_start;
        (latch_reg.off && !off_d_reg && supply_ok_f) |=> dinh_reg [*8];
    endproperty
    a_inh_start: assert property (p_inh_start) else $error("decode inhibit not held"); // see [R09]

    property p_inh_clear;
        !supply_ok_f |=> !dinh_reg && lcn_reg;
    endproperty
    a_inh_clear: assert property (p_inh_clear) else $error("supply fault ignored"); // see [R10]

    property p_pulse_cause;
        $fell(lcn_reg) |-> $past(lc_state_reg) == LC_DELAY || $past(off_now);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without cause"); // see [R13]

    property p_strobe;
        !lcn_reg |=> strobe_reg;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe missed change"); // see [R16]

    property p_gate;
        (!inh_n_reg |-> gated_reg == '0) and ($rose(|gated_reg) |-> ton_reg);
    endproperty
    a_gate: assert property (p_gate) else $error("gating wrong"); // see [R19]

    property p_contactor;
        (severe_f || secondary_f) |=> !inh_n_reg;
    endproperty
    a_contactor: assert property (p_contactor) else $error("contactor not inhibited"); // see [R21]

    c_pulse: cover property ($fell(lcn_reg));
    c_off_now: cover property (off_now && supply_ok_f);
    c_inhibit: cover property ($rose(dinh_reg));
    c_turn_on: cover property ($rose(ton_reg));

endmodule

// file: tb_top.sv
// Self-checking bench for the power command priority latch.
// Assumes shortened timer parameters and the panel model on the pins.
`timescale 1ns/100ps
module tb_top;
    import pcpl_pkg::*;
    localparam int unsigned TK = 10;
    localparam int unsigned DL = 20;
    localparam int unsigned PW = 10;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
    logic pclk, presetn, backup_rst_n, psel, penable, pwrite, local_sel;
    logic secondary_fault, supply_fault_n, other_strobe, vswr_fault, severe_fault;
    logic interlock_fault, pready, pslverr, debounce_tick, raise_cmd, lower_cmd;
    logic level_change_n, data_strobe, contactor_inhibit_n, turn_on_request;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic e;
    logic [2:0] gated_level;
    pcpl_cmd_s local_cmd_n, remote_cmd_n, dec_n;
    pcpl_lvl_s power_level_latch;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    pcpl_top #(.TICK_CYCLES(TK), .INHIBIT_CYCLES(100), .DELAY_CYCLES(DL),
        .PULSE_CYCLES(PW)) u_pcpl_top (.pclk(pclk), .presetn(presetn),
        .backup_rst_n(backup_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .local_cmd_n(local_cmd_n), .remote_cmd_n(remote_cmd_n),
        .local_sel(local_sel), .vswr_fault(vswr_fault), .severe_fault(severe_fault),
        .interlock_fault(interlock_fault), .secondary_fault(secondary_fault),
        .supply_fault_n(supply_fault_n), .other_strobe(other_strobe),
        .debounce_tick(debounce_tick), .dec_n(dec_n), .raise_cmd(raise_cmd),
        .lower_cmd(lower_cmd), .level_change_n(level_change_n),
        .data_strobe(data_strobe), .power_level_latch(power_level_latch),
        .gated_level(gated_level), .contactor_inhibit_n(contactor_inhibit_n),
        .turn_on_request(turn_on_request));
    pcpl_panel #(.HOLD_CYCLES(4 * TK)) u_pcpl_panel (.pclk(pclk),
        .local_cmd_n(local_cmd_n), .remote_cmd_n(remote_cmd_n),
        .vswr_fault(vswr_fault), .severe_fault(severe_fault),
        .interlock_fault(interlock_fault));
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wlc(input logic v, output int n);
        n = 0;
        while (level_change_n !== v) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic wdec(input int i, input logic v, output int n);
        n = 0;
        while (dec_n[i] !== v) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic t_level();
        int n, w;
        u_pcpl_panel.hold(1'b0, 6'h04);
        wdec(C_HIGH, 1'b0, n);
        `CHK(n >= 3 * TK && n <= 4 * TK + 6, 1'b1)
        wlc(1'b0, n);
        `CHK(n >= DL && n <= DL + 2, 1'b1)
        @(posedge pclk);
        `CHK(data_strobe, 1'b1)
        wlc(1'b1, w);
        `CHK(w + 1, PW)
        repeat (3) @(posedge pclk);
        `CHK(power_level_latch, 4'h4)
        `CHK(gated_level, 3'h4)
        `CHK(turn_on_request, 1'b1)
    endtask
    task automatic t_off();
        int n, w;
        u_pcpl_panel.fault(3'h2);
        wdec(C_OFF, 1'b0, n);
        wlc(1'b0, n);
        `CHK(n <= 3, 1'b1)
        wlc(1'b1, w);
        repeat (3) @(posedge pclk);
        `CHK(power_level_latch, 4'h8)
        `CHK(contactor_inhibit_n, 1'b0)
        `CHK({gated_level, turn_on_request}, 4'h0)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(r[ST_DEC_INH], 1'b1)
        supply_fault_n <= 1'b0;
        u_pcpl_panel.fault(3'h0);
        u_pcpl_panel.release_all();
        repeat (8) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(r[ST_DEC_INH], 1'b0)
        u_pcpl_panel.hold(1'b0, 6'h01);
        w = 0;
        repeat (150) begin
            @(posedge pclk);
            if (level_change_n !== 1'b1) w++;
        end
        `CHK(w, 0)
        u_pcpl_panel.release_all();
        repeat (100) @(posedge pclk);
        supply_fault_n <= 1'b1;
        repeat (200) @(posedge pclk);
    endtask
    task automatic t_remote();
        int n;
        local_sel <= 1'b1;
        u_pcpl_panel.hold(1'b1, 6'h02);
        repeat (100) @(posedge pclk);
        `CHK(dec_n, 6'h3f)
        local_sel <= 1'b0;
        wdec(C_MED, 1'b0, n);
        `CHK(n < 100, 1'b1)
        wlc(1'b0, n);
        wlc(1'b1, n);
        u_pcpl_panel.release_all();
        repeat (3) @(posedge pclk);
        `CHK({gated_level, turn_on_request}, 4'h5)
        secondary_fault <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK({contactor_inhibit_n, gated_level}, 4'h0)
        secondary_fault <= 1'b0;
    endtask
    task automatic t_prio();
        int n;
        u_pcpl_panel.hold(1'b0, 6'h19);
        wdec(C_LOWER, 1'b0, n);
        @(posedge pclk);
        `CHK(dec_n, 6'h2f)
        `CHK({lower_cmd, raise_cmd}, 2'h2)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(r[ST_CODE +: 3], 3'h6)
        u_pcpl_panel.release_all();
        wdec(C_LOWER, 1'b1, n);
        `CHK(lower_cmd, 1'b0)
        u_pcpl_panel.fault(3'h4);
        wdec(C_LOWER, 1'b0, n);
        `CHK(n < 100, 1'b1)
        u_pcpl_panel.fault(3'h1);
        wdec(C_OFF, 1'b0, n);
        `CHK(n < 100, 1'b1)
        u_pcpl_panel.fault(3'h0);
        repeat (200) @(posedge pclk);
    endtask
    task automatic t_misc();
        int n;
        other_strobe <= 1'b1;
        @(posedge pclk);
        other_strobe <= 1'b0;
        #1;
        `CHK(data_strobe, 1'b1)
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            if (debounce_tick === 1'b1) n++;
        end
        `CHK(n, 100 / TK)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({e, r}, 33'h100000000)
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(r[5:0], 6'h01)
        wlc(1'b0, n);
        wlc(1'b1, n);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK(power_level_latch, 4'h1)
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK({contactor_inhibit_n, dec_n}, 7'h3f)
        @(posedge pclk);
        presetn <= 1'b1;
        `CHK(power_level_latch, 4'h1)
        backup_rst_n <= 1'b0;
        @(posedge pclk);
        #1;
        `CHK(power_level_latch, 4'h0)
        @(posedge pclk);
        backup_rst_n <= 1'b1;
    endtask
    initial begin
        {presetn, backup_rst_n, psel, penable, pwrite, local_sel} = 6'h0;
        {secondary_fault, supply_fault_n, other_strobe, paddr, pwdata} = '0;
        supply_fault_n = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        backup_rst_n <= 1'b1;
        t_level();
        t_off();
        t_remote();
        t_prio();
        t_misc();
        complete_run();
    end
endmodule
